// >>> rtl/exc_seq_pkg.sv
package exc_seq_pkg;

  localparam int VEC_W = 6;
  localparam int ADDR_W = 8;
  localparam int VEC_SHIFT = 2;
  localparam logic [VEC_W-1:0] VEC_RESET = 6'h00;
  localparam logic [VEC_W-1:0] VEC_NMI = 6'h07;
  localparam logic [VEC_W-1:0] VEC_TRAP_BASE = 6'h08;
  localparam logic [VEC_W-1:0] VEC_IRQ_FIRST = 6'h0c;
  localparam logic [VEC_W-1:0] VEC_INT_LAST = 6'h3f;
  localparam int RST_PIN_MIN_CYCLES = 10;
  localparam int WDT_HOLD_CYCLES = 10;
  localparam int CNT_W = 16;
  localparam logic NMI_EDGE_FALL = 1'b0;
  localparam logic UFS_RESET = 1'b1;

  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_RUN   = 5'b00010,
    ST_PUSH  = 5'b00100,
    ST_MASK  = 5'b01000,
    ST_FETCH = 5'b10000
  } exc_state_type;

  typedef struct packed {
    logic user_flag_select;
    logic nmi_edge_select;
  } exc_cfg_type;

  typedef struct packed {
    logic imask;
    logic aux_mask_flag;
  } ccr_mask_type;

  typedef struct packed {
    logic           valid;
    logic [VEC_W-1:0] vec;
  } irq_req_type;

endpackage : exc_seq_pkg

// >>> rtl/exception_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - Reset beats interrupts, interrupts beat traps
// - Traps accepted always while running
// - Reset handling starts on reset pin rise
// - Interrupts taken only at instruction boundary
// - Push state, set mask, then fetch vector
// - Reset skips stack push
// - Vector address is four times number
// - Reset pin low halts and holds
// - Reset exit initialises and sets mask
// - Reset fetches vector zero, then runs
// - Watchdog overflow also resets chip
// - All interrupts blocked until first instruction
// - First instruction never pre-empted
// - Seven external, 36 internal sources, distinct vectors
// - Nonmaskable interrupt highest, ignores mask
// - Controller arbitrates two-level maskable requests
// - Trap sets aux mask when select bit low
// - Trap code picks one of four vectors
// - User flag select resets to one
// - Nonmaskable edge chosen by edge select
module exception_sequencer #(
  parameter int WDT_HOLD = exc_seq_pkg::WDT_HOLD_CYCLES
) (
  input  wire logic                       mclk_in,          // System clock
  input  wire logic                       rst_in,           // Async reset
  input  wire logic                       chip_init_pin_n_in, // Reset pin, low active
  input  wire logic                       wdt_overflow_in,  // Watchdog overflow pulse
  input  wire exc_seq_pkg::exc_cfg_type   cfg_in,           // Control bits
  input  wire exc_seq_pkg::ccr_mask_type  ccr_in,           // Current mask flags
  input  wire logic                       nmi_pin_in,       // Nonmaskable pin
  input  wire exc_seq_pkg::irq_req_type   irq_in,           // Arbitrated request
  input  wire logic                       insn_done_in,     // Instruction end pulse
  input  wire logic                       trap_req_in,      // Trap executed
  input  wire logic [1:0]                 trap_num_in,      // Trap vector code
  input  wire logic                       push_done_in,     // Stack save done
  input  wire logic                       fetch_done_in,    // Vector fetch done
  output logic                            halt_out,         // In reset state
  output logic                            init_out,         // Initialise pulse
  output logic                            push_req_out,     // Save PC and flags
  output logic                            set_imask_out,    // Set mask pulse
  output logic                            set_aux_out,      // Set aux mask pulse
  output logic                            fetch_req_out,    // Fetch vector
  output logic [exc_seq_pkg::VEC_W-1:0]   vec_num_out,      // Vector number
  output logic [exc_seq_pkg::ADDR_W-1:0]  vec_addr_out,     // Vector address
  output logic                            irq_ack_out,      // Request taken pulse
  output logic                            busy_out          // Exception in progress
);
  import exc_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (WDT_HOLD < 1 || WDT_HOLD >= (1 << CNT_W)) begin : g_bad_hold
    $error("WDT_HOLD out of range");
  end

  function automatic logic [ADDR_W-1:0] vec_to_addr(input logic [VEC_W-1:0] num);
    vec_to_addr = {num, {VEC_SHIFT{1'b0}}};
  endfunction : vec_to_addr

  ////////////////////////////////////////////////////////////////////////////
  // State
  exc_state_type          state_q, state_d;
  logic [CNT_W-1:0]       wdt_cnt_q, wdt_cnt_d;
  logic                   nmi_prev_q, nmi_prev_d;
  logic                   nmi_pend_q, nmi_pend_d;
  logic                   trap_pend_q, trap_pend_d;
  logic [1:0]             trap_num_q, trap_num_d;
  logic                   first_q, first_d;
  logic                   is_trap_q, is_trap_d;
  logic                   halt_d, init_d, push_d, set_i_d, set_ui_d, fetch_d;
  logic                   ack_d, busy_d;
  logic [VEC_W-1:0]       vec_d;
  logic [ADDR_W-1:0]      addr_d;
  logic                   pin_low, nmi_edge;

  always_comb begin
    pin_low = ~chip_init_pin_n_in;
    nmi_edge = (cfg_in.nmi_edge_select == NMI_EDGE_FALL) ? (nmi_prev_q & ~nmi_pin_in)
                                                         : (~nmi_prev_q & nmi_pin_in);
    state_d = state_q;
    wdt_cnt_d = wdt_cnt_q;
    nmi_prev_d = nmi_pin_in;
    nmi_pend_d = nmi_pend_q;
    trap_pend_d = trap_pend_q;
    trap_num_d = trap_num_q;
    first_d = first_q;
    is_trap_d = is_trap_q;
    init_d = 1'b0;
    push_d = push_req_out;
    set_i_d = 1'b0;
    set_ui_d = 1'b0;
    fetch_d = fetch_req_out;
    ack_d = 1'b0;
    vec_d = vec_num_out;
    if (trap_req_in && insn_done_in) begin
      trap_pend_d = 1'b1;
      trap_num_d = trap_num_in;
    end
    unique case (state_q)
      ST_RESET: begin
        if (wdt_cnt_q != '0) begin
          wdt_cnt_d = wdt_cnt_q - 1'b1;
        end
        if (!pin_low && wdt_cnt_q == '0) begin
          state_d = ST_MASK;
          init_d = 1'b1;
          vec_d = VEC_RESET;
          is_trap_d = 1'b0;
          first_d = 1'b1;
          nmi_pend_d = 1'b0;
          trap_pend_d = 1'b0;
        end
      end
      ST_RUN: begin
        if (insn_done_in) begin
          first_d = 1'b0;
        end
        if (insn_done_in && !first_q && nmi_pend_q) begin
          state_d = ST_PUSH;
          push_d = 1'b1;
          vec_d = VEC_NMI;
          is_trap_d = 1'b0;
          nmi_pend_d = 1'b0;
        end else if (insn_done_in && !first_q && irq_in.valid && !ccr_in.imask) begin
          state_d = ST_PUSH;
          push_d = 1'b1;
          vec_d = irq_in.vec;
          is_trap_d = 1'b0;
          ack_d = 1'b1;
        end else if (trap_pend_q || (trap_req_in && insn_done_in)) begin
          state_d = ST_PUSH;
          push_d = 1'b1;
          vec_d = VEC_W'(VEC_TRAP_BASE + (trap_pend_q ? trap_num_q : trap_num_in));
          is_trap_d = 1'b1;
          trap_pend_d = 1'b0;
        end
      end
      ST_PUSH: begin
        if (push_done_in) begin
          push_d = 1'b0;
          state_d = ST_MASK;
        end
      end
      ST_MASK: begin
        set_i_d = 1'b1;
        set_ui_d = is_trap_q && !cfg_in.user_flag_select;
        fetch_d = 1'b1;
        state_d = ST_FETCH;
      end
      ST_FETCH: begin
        if (fetch_done_in) begin
          fetch_d = 1'b0;
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RESET;
    endcase
    if (nmi_edge && state_q != ST_RESET) begin
      nmi_pend_d = 1'b1;
    end
    if (pin_low || wdt_overflow_in) begin
      state_d = ST_RESET;
      push_d = 1'b0;
      fetch_d = 1'b0;
      set_i_d = 1'b0;
      set_ui_d = 1'b0;
      init_d = 1'b0;
      ack_d = 1'b0;
      if (wdt_overflow_in) begin
        wdt_cnt_d = CNT_W'(WDT_HOLD);
      end
    end
    addr_d = vec_to_addr(vec_d);
    halt_d = (state_d == ST_RESET);
    busy_d = (state_d == ST_PUSH) || (state_d == ST_MASK) || (state_d == ST_FETCH);
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_RESET;
      wdt_cnt_q <= '0;
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      trap_num_q <= 2'h0;
      first_q <= 1'b1;
      is_trap_q <= 1'b0;
      halt_out <= 1'b1;
      init_out <= 1'b0;
      push_req_out <= 1'b0;
      set_imask_out <= 1'b0;
      set_aux_out <= 1'b0;
      fetch_req_out <= 1'b0;
      vec_num_out <= VEC_RESET;
      vec_addr_out <= 8'h00;
      irq_ack_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      state_q <= state_d;
      wdt_cnt_q <= wdt_cnt_d;
      nmi_prev_q <= nmi_prev_d;
      nmi_pend_q <= nmi_pend_d;
      trap_pend_q <= trap_pend_d;
      trap_num_q <= trap_num_d;
      first_q <= first_d;
      is_trap_q <= is_trap_d;
      halt_out <= halt_d;
      init_out <= init_d;
      push_req_out <= push_d;
      set_imask_out <= set_i_d;
      set_aux_out <= set_ui_d;
      fetch_req_out <= fetch_d;
      vec_num_out <= vec_d;
      vec_addr_out <= addr_d;
      irq_ack_out <= ack_d;
      busy_out <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_pin_low_halts: assert property (!chip_init_pin_n_in |=> halt_out && !push_req_out)
    else $error("reset pin low did not halt");
  a_wdt_resets: assert property (wdt_overflow_in |=> halt_out && state_q == ST_RESET)
    else $error("watchdog overflow did not reset");
  a_pin_rise_exit: assert property ((state_q == ST_RESET && chip_init_pin_n_in && wdt_cnt_q == '0
                                     && !wdt_overflow_in) |=> init_out)
    else $error("reset exit not immediate");
  a_reset_no_push: assert property ((init_out && chip_init_pin_n_in && !wdt_overflow_in)
                                    |-> !push_req_out ##1 set_imask_out && !set_aux_out)
    else $error("reset entry pushed or missed mask");
  a_reset_vector: assert property ((init_out && chip_init_pin_n_in && !wdt_overflow_in)
                                   |=> fetch_req_out && vec_addr_out == 8'h00)
    else $error("reset vector not fetched");
  a_push_order: assert property ((push_req_out && push_done_in && chip_init_pin_n_in
                                  && !wdt_overflow_in) |=> !push_req_out ##1 set_imask_out)
    else $error("mask not set after push");
  a_boundary_only: assert property ($rose(push_req_out) && !is_trap_q |-> $past(insn_done_in))
    else $error("exception entered mid instruction");
  a_first_blocked: assert property ((state_q == ST_RUN && first_q) |=> !irq_ack_out
                                    && !(push_req_out && !is_trap_q))
    else $error("interrupt taken before first instruction");
  a_mask_refuse: assert property ((state_q == ST_RUN && ccr_in.imask) |=> !irq_ack_out)
    else $error("maskable request taken while masked");
  a_nmi_wins: assert property ((state_q == ST_RUN && insn_done_in && !first_q && nmi_pend_q
                                && chip_init_pin_n_in && !wdt_overflow_in)
                               |=> push_req_out && vec_num_out == VEC_NMI && !irq_ack_out)
    else $error("nonmaskable not taken first");
  a_trap_aux: assert property ((set_imask_out && is_trap_q)
                               |-> set_aux_out == !$past(cfg_in.user_flag_select))
    else $error("aux mask wrong on trap");
  a_trap_vector: assert property ((push_req_out && is_trap_q) |-> vec_addr_out >= 8'h20
                                  && vec_addr_out <= 8'h2c && vec_addr_out[1:0] == 2'h0)
    else $error("trap vector out of range");

  c_reset_exit: cover property (init_out ##1 set_imask_out ##1 fetch_req_out);
  c_trap_taken: cover property (push_req_out && is_trap_q ##[1:20] set_aux_out);
  c_nmi_taken: cover property (push_req_out && vec_num_out == VEC_NMI);
  c_irq_taken: cover property (irq_ack_out);

endmodule : exception_sequencer

// >>> sim/core_model.sv
`timescale 1ns/1ps
module core_model #(
  parameter int LAT = 2
) (
  input  wire logic mclk_in,  // System clock
  input  wire logic rst_in,   // Async reset
  input  wire logic req_in,   // Push or fetch request
  output logic      done_out  // Completion pulse
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       done_d;
  // One pulse LAT+1 cycles into a held request
  always_comb begin
    cnt_d  = req_in ? cnt_q + 4'h1 : 4'h0;
    done_d = req_in && (cnt_q == LAT[3:0]);
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q    <= 4'h0;
      done_out <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      done_out <= done_d;
    end
  end
endmodule : core_model

// >>> sim/exception_sequencer_test.sv
`timescale 1ns/1ps
module exception_sequencer_test;
  import exc_seq_pkg::*;
  typedef struct packed {
    logic nes, nmi, iv; logic [5:0] ivv; logic tr; logic [1:0] code;
    logic im, ufs, take, ack, aux; logic [5:0] xv;
  } row_type;
  logic mclk_in = 0, rst_in = 1, pin_n = 1, wdt = 0, nmi = 1, insn = 0, trap = 0;
  logic [1:0] code = 2'h0;
  exc_cfg_type  cfg = 2'h2;
  ccr_mask_type cond_flags_reg = 2'h0;
  irq_req_type  irq = 7'h00;
  logic halt, init, preq, simask, saux, freq, ack, busy, pdone, fdone;
  logic [5:0] vnum;
  logic [7:0] vaddr;
  int n_fail = 0, checks_done = 0, cyc = 0;
  row_type rows[9];
  ////////////////////////////////////////////////////////////
  exception_sequencer #(.WDT_HOLD(2)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .chip_init_pin_n_in(pin_n), .wdt_overflow_in(wdt), .cfg_in(cfg), .ccr_in(cond_flags_reg),
    .nmi_pin_in(nmi), .irq_in(irq), .insn_done_in(insn), .trap_req_in(trap),
    .trap_num_in(code), .push_done_in(pdone), .fetch_done_in(fdone), .halt_out(halt),
    .init_out(init), .push_req_out(preq), .set_imask_out(simask), .set_aux_out(saux),
    .fetch_req_out(freq), .vec_num_out(vnum), .vec_addr_out(vaddr), .irq_ack_out(ack),
    .busy_out(busy));
  core_model #(.LAT(1)) i_push (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(preq), .done_out(pdone));
  core_model #(.LAT(3)) i_fetch (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(freq), .done_out(fdone));
  ////////////////////////////////////////////////////////////
  initial forever #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task chk(string nm, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task tick;
    @(posedge mclk_in);
    #1;
  endtask : tick
  task reset_walk;
    for (int i = 0; i < 20 && !init; i++) tick;
    chk("init", 1, init);
    chk("halt", 0, halt);
    tick;
    chk("imask", 1, simask);
    chk("push", 0, preq);
    tick;
    chk("fetch", 1, freq);
    chk("addr", 0, vaddr);
    for (int i = 0; i < 20 && busy; i++) tick;
    chk("busy", 0, busy);
    $display("reset test done");
  endtask : reset_walk
  task run_row(int k, row_type r);
    @(posedge mclk_in);
    cfg <= {r.ufs, r.nes};
    cond_flags_reg <= {r.im, 1'b0};
    nmi <= r.nmi;
    repeat (3) @(posedge mclk_in);
    insn <= 1;
    irq  <= {r.iv, r.ivv};
    trap <= r.tr;
    code <= r.code;
    @(posedge mclk_in);
    insn <= 0;
    irq  <= 7'h00;
    trap <= 0;
    #1;
    for (int i = 0; i < 4 && !preq; i++) tick;
    chk("take", r.take, preq);
    if (r.take) begin
      chk("ack", r.ack, ack);
      chk("vec", r.xv, vnum);
      chk("addr", {r.xv, 2'b00}, vaddr);
      for (int i = 0; i < 20 && !simask; i++) tick;
      chk("order", 0, preq);
      chk("aux", r.aux, saux);
      for (int i = 0; i < 20 && busy; i++) tick;
      chk("busy", 0, busy);
      if (r.tr && r.xv != 6'(VEC_TRAP_BASE + r.code)) begin
        for (int i = 0; i < 4 && !preq; i++) tick;
        chk("late push", 1, preq);
        chk("late trap", 8'(VEC_TRAP_BASE + r.code), vnum);
        for (int i = 0; i < 20 && busy; i++) tick;
        chk("late busy", 0, busy);
      end
    end
    $display("row %0d done", k);
  endtask : run_row
  ////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{0, 1, 1, 6'h0c, 0, 0, 0, 1, 0, 0, 0, 0};
    rows[1] = '{0, 1, 1, 6'h0c, 0, 0, 0, 1, 1, 1, 0, 6'h0c};
    rows[2] = '{0, 1, 1, 6'h3f, 0, 0, 0, 1, 1, 1, 0, 6'h3f};
    rows[3] = '{0, 1, 1, 6'h11, 0, 0, 1, 1, 0, 0, 0, 0};
    rows[4] = '{0, 1, 0, 0, 1, 0, 0, 1, 1, 0, 0, 6'h08};
    rows[5] = '{0, 1, 0, 0, 1, 3, 1, 0, 1, 0, 1, 6'h0b};
    rows[6] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 0, 0, 6'h07};
    rows[7] = '{1, 1, 1, 6'h0d, 1, 2, 0, 1, 1, 0, 0, 6'h07};
    rows[8] = '{1, 1, 1, 6'h0e, 1, 1, 0, 1, 1, 1, 0, 6'h0e};
    repeat (2) @(posedge mclk_in);
    rst_in <= 0;
    reset_walk;
    foreach (rows[k]) run_row(k, rows[k]);
    @(posedge mclk_in);
    wdt <= 1;
    @(posedge mclk_in);
    wdt <= 0;
    #1;
    chk("wdt halt", 1, halt);
    reset_walk;
    @(posedge mclk_in);
    pin_n <= 0;
    repeat (10) @(posedge mclk_in);
    #1;
    chk("pin halt", 1, halt);
    @(posedge mclk_in);
    pin_n <= 1;
    reset_walk;
    complete_run;
  end
endmodule : exception_sequencer_test
